// ===== src/transceiver_power_mode_ctrl.sv
// Purpose: operating-mode controller: Off, Hibernate, Doze, Acoma, Idle and active modes
// Assumes: rst is the device reset pin; pins other than rst and op_done are asynchronous
// Notes:   the oscillator is modelled by osc_enable; clk itself keeps running
`timescale 1ns/10ps
module transceiver_power_mode_ctrl
  import power_mode_pkg::*;
#(
  parameter logic [22:0] OFF_TO_IDLE_CYCLES = CYC_OFF_TO_IDLE,
  parameter logic [22:0] HIB_TO_IDLE_CYCLES = CYC_HIB_TO_IDLE,
  parameter logic [22:0] DOZE_EXIT_CYCLES   = CYC_DOZE_EXIT,
  parameter logic [22:0] WARMUP_CYCLES      = CYC_WARMUP,
  parameter int          PRESCALE           = PRESCALE_DIV
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic wake_pin_n,
  input  wire logic radio_activity_enable_pin,
  input  wire logic spi_sclk,
  input  wire logic spi_cs_n,
  input  wire logic spi_mosi,
  input  wire logic op_done,
  output logic      spi_miso,
  output logic      spi_miso_oe,
  output logic      clko,
  output logic      clko_oe,
  output logic      irq_n,
  output logic      irq_n_oe,
  output logic      osc_enable,
  output logic      rx_on,
  output logic      tx_on,
  output logic      cca_on
);
  typedef struct packed {
    mode_t       mode;
    logic [22:0] wait_cnt;
    logic [7:0]  edge_cnt;
    logic        to_hib;
    logic        doze_clko_on;
    logic        clko_blocked;
    logic        seq_armed;
    logic [15:0] irq_mask;
    logic [15:0] seq_ctrl;
    logic [15:0] lp_ctrl;
    logic [15:0] clko_ctrl;
    logic [23:0] wake_cmp;
    logic [15:0] stream_cmp;
    logic [15:0] status;
    logic [23:0] event_timer;
    logic [7:0]  pre_cnt;
    logic [8:0]  div_cnt;
    logic        clko;
    logic        clko_oe;
    logic        irq_n;
    logic        irq_oe;
    logic        osc;
    logic        rx_on;
    logic        tx_on;
    logic        cca_on;
  } ctrl_t;

  ctrl_t       s;
  ctrl_t       next_s;
  logic [4:0]  pins_q;
  logic        wake_q;
  logic        radio_activity_enable_pin_q;
  logic        rd_req;
  logic        wr_req;
  logic [5:0]  reg_addr;
  logic [15:0] wdata;
  logic [15:0] rdata;

  if (PRESCALE < 2 || PRESCALE > 256 || OFF_TO_IDLE_CYCLES == 23'h0 ||
      HIB_TO_IDLE_CYCLES == 23'h0 || DOZE_EXIT_CYCLES == 23'h0 ||
      WARMUP_CYCLES == 23'h0) begin : g_chk
    $error("transceiver_power_mode_ctrl: unsupported timing parameters");
  end

  pin_sync #(
    .WIDTH     (5),
    .RESET_VAL (PIN_RESET)
  ) u_sync (
    .clk    (clk),
    .rst    (rst),
    .pins   ({wake_pin_n, radio_activity_enable_pin, spi_sclk, spi_cs_n, spi_mosi}),
    .synced (pins_q)
  );

  assign wake_q   = !pins_q[4];
  assign radio_activity_enable_pin_q = pins_q[3];

  serial_reg_port u_port (
    .clk     (clk),
    .rst     (rst),
    .enable  (s.mode == MODE_IDLE || s.mode == MODE_ARMED || s.mode == MODE_WARMUP ||
              s.mode == MODE_RX || s.mode == MODE_TX || s.mode == MODE_CCA),
    .sclk    (pins_q[2]),
    .cs_n    (pins_q[1]),
    .mosi    (pins_q[0]),
    .rdata   (rdata),
    .rd_req  (rd_req),
    .wr_req  (wr_req),
    .addr    (reg_addr),
    .wdata   (wdata),
    .miso    (spi_miso),
    .miso_oe (spi_miso_oe)
  );

  always_comb begin
    case (reg_addr)
      ADDR_IRQ_MASK:   rdata = s.irq_mask;
      ADDR_SEQ_CTRL:   rdata = s.seq_ctrl;
      ADDR_LP_CTRL:    rdata = s.lp_ctrl;
      ADDR_CLKO_CTRL:  rdata = s.clko_ctrl;
      ADDR_WAKE_HI:    rdata = {8'h00, s.wake_cmp[23:16]};
      ADDR_WAKE_LO:    rdata = s.wake_cmp[15:0];
      ADDR_STREAM_CMP: rdata = s.stream_cmp;
      ADDR_IRQ_STATUS: rdata = s.status;
      ADDR_MODE_STAT:  rdata = {12'h000, s.mode};
      default:         rdata = 16'h0000;
    endcase
  end

  always_comb begin
    logic [2:0] rate;
    logic       clko_tick;
    logic       tick;
    logic       acoma;
    logic       pkt_req;
    logic       strm_req;
    logic       use_strm;
    logic       match_pkt;
    logic       match_strm;
    logic       timer_run;
    logic       clko_run;
    logic       in_doze;
    rate       = s.clko_ctrl[CLKO_RATE_LSB +: 3];
    acoma      = s.irq_mask[BIT_ACOMA_EN];
    use_strm   = s.seq_ctrl[BIT_USE_STRM];
    next_s     = s;
    next_s.div_cnt = s.div_cnt + 9'h001;
    clko_tick  = !s.div_cnt[rate] && next_s.div_cnt[rate];
    // Timers frozen while the oscillator is down or in Acoma
    timer_run  = s.mode != MODE_OFF && s.mode != MODE_BOOT && s.mode != MODE_HIBERNATE &&
                 s.mode != MODE_HIB_WAKE && !(s.mode == MODE_DOZE && acoma);
    tick       = timer_run && (s.pre_cnt == 8'(PRESCALE - 1));
    match_pkt  = timer_run && s.pre_cnt == 8'h00 && s.event_timer == s.wake_cmp;
    match_strm = timer_run && s.pre_cnt == 8'h00 && s.event_timer[15:0] == s.stream_cmp;
    pkt_req    = !use_strm && s.seq_ctrl[1:0] != SEQ_IDLE;
    strm_req   = use_strm && (s.seq_ctrl[BIT_TX_STRM] ^ s.seq_ctrl[BIT_RX_STRM]);
    if (timer_run) begin
      next_s.pre_cnt = tick ? 8'h00 : s.pre_cnt + 8'h01;
      if (tick) begin
        next_s.event_timer = s.event_timer + 24'h000001;
      end
    end

    if (rd_req && reg_addr == ADDR_IRQ_STATUS) begin
      next_s.status = 16'h0000;
    end
    if (wr_req) begin
      case (reg_addr)
        ADDR_IRQ_MASK:   next_s.irq_mask = wdata;
        ADDR_SEQ_CTRL: begin
          next_s.seq_ctrl = wdata;
          next_s.seq_armed = 1'b1;
        end
        ADDR_LP_CTRL:    next_s.lp_ctrl = wdata;
        ADDR_CLKO_CTRL:  next_s.clko_ctrl = wdata;
        ADDR_WAKE_HI:    next_s.wake_cmp[23:16] = wdata[7:0];
        ADDR_WAKE_LO:    next_s.wake_cmp[15:0] = wdata;
        ADDR_STREAM_CMP: next_s.stream_cmp = wdata;
        default: begin
        end
      endcase
    end
    // Slow rates stay off until the host toggles the enable
    if (!next_s.clko_ctrl[BIT_CLKO_EN]) begin
      next_s.clko_blocked = 1'b0;
    end

    if (s.wait_cnt != 23'h0) begin
      next_s.wait_cnt = s.wait_cnt - 23'h000001;
    end
    case (s.mode)
      MODE_OFF: begin
        next_s.mode = MODE_BOOT;
        next_s.wait_cnt = OFF_TO_IDLE_CYCLES - 23'h000001;
      end
      MODE_BOOT: begin
        if (s.wait_cnt == 23'h0) begin
          next_s.mode = MODE_IDLE;
        end
      end
      MODE_IDLE: begin
        if (s.lp_ctrl[BIT_HIB_EN] || s.lp_ctrl[BIT_DOZE_EN]) begin
          // Only honoured here, so a write in an active mode waits for Idle
          next_s.mode = MODE_ENTER;
          next_s.to_hib = s.lp_ctrl[BIT_HIB_EN];
          next_s.edge_cnt = 8'h00;
        end else if (radio_activity_enable_pin_q && s.seq_armed && (pkt_req || strm_req)) begin
          next_s.seq_armed = 1'b0;
          if (s.seq_ctrl[BIT_TRIG_EN]) begin
            next_s.mode = MODE_ARMED;
          end else begin
            next_s.mode = MODE_WARMUP;
            next_s.wait_cnt = WARMUP_CYCLES - 23'h000001;
          end
        end
      end
      MODE_ENTER: begin
        if (clko_tick) begin
          next_s.edge_cnt = s.edge_cnt + 8'h01;
          if (s.edge_cnt == LP_EDGES_LAST) begin
            next_s.lp_ctrl[BIT_HIB_EN] = 1'b0;
            next_s.lp_ctrl[BIT_DOZE_EN] = 1'b0;
            next_s.edge_cnt = 8'h00;
            next_s.doze_clko_on = 1'b1;
            next_s.mode = s.to_hib ? MODE_HIBERNATE : MODE_DOZE;
          end
        end
      end
      MODE_HIBERNATE: begin
        if (wake_q) begin
          next_s.mode = MODE_HIB_WAKE;
          next_s.wait_cnt = HIB_TO_IDLE_CYCLES - 23'h000001;
        end
      end
      MODE_HIB_WAKE: begin
        if (s.wait_cnt == 23'h0) begin
          next_s.mode = MODE_IDLE;
        end
      end
      MODE_DOZE: begin
        if (clko_tick && s.doze_clko_on && !s.lp_ctrl[BIT_CLKO_DOZE] && !acoma) begin
          next_s.edge_cnt = s.edge_cnt + 8'h01;
          if (s.edge_cnt == LP_EDGES_LAST) begin
            next_s.doze_clko_on = 1'b0;
          end
        end
        if (wake_q || (!acoma && match_pkt)) begin
          next_s.mode = MODE_DOZE_WAKE;
          next_s.wait_cnt = DOZE_EXIT_CYCLES - 23'h000001;
          if (!wake_q) begin
            next_s.status[BIT_ST_DOZE] = 1'b1;
          end
        end
      end
      MODE_DOZE_WAKE: begin
        if (s.wait_cnt == 23'h0 && clko_tick) begin
          next_s.mode = MODE_IDLE;
          next_s.doze_clko_on = 1'b1;
          if (!s.doze_clko_on && rate >= CLKO_SLOW_MIN) begin
            next_s.clko_blocked = 1'b1;
          end
        end
      end
      MODE_ARMED: begin
        if (!radio_activity_enable_pin_q) begin
          next_s.mode = MODE_IDLE;
        end else if (use_strm ? match_strm : match_pkt) begin
          next_s.status[BIT_ST_TMR2] = 1'b1;
          next_s.mode = MODE_WARMUP;
          next_s.wait_cnt = WARMUP_CYCLES - 23'h000001;
        end
      end
      MODE_WARMUP: begin
        if (s.wait_cnt == 23'h0) begin
          if (use_strm) begin
            next_s.mode = s.seq_ctrl[BIT_TX_STRM] ? MODE_TX : MODE_RX;
          end else begin
            case (s.seq_ctrl[1:0])
              SEQ_CCA: next_s.mode = MODE_CCA;
              SEQ_RX:  next_s.mode = MODE_RX;
              SEQ_TX:  next_s.mode = MODE_TX;
              default: next_s.mode = MODE_IDLE;
            endcase
          end
        end
      end
      MODE_RX, MODE_TX, MODE_CCA: begin
        if (op_done) begin
          next_s.mode = MODE_IDLE;
        end
      end
      default: next_s.mode = MODE_IDLE;
    endcase

    in_doze = next_s.mode == MODE_DOZE || next_s.mode == MODE_DOZE_WAKE;
    // Clock output keeps its rate field, so a restart resumes the old frequency
    clko_run = next_s.clko_ctrl[BIT_CLKO_EN] && !next_s.clko_blocked &&
               next_s.mode != MODE_BOOT && next_s.mode != MODE_HIBERNATE &&
               next_s.mode != MODE_HIB_WAKE && (!in_doze || next_s.doze_clko_on);
    next_s.clko = clko_run && next_s.div_cnt[rate];
    next_s.osc = next_s.mode != MODE_HIBERNATE;
    next_s.irq_n = !((next_s.status[BIT_ST_DOZE] && s.irq_mask[BIT_DOZE_MASK]) ||
                     (next_s.status[BIT_ST_TMR2] && s.irq_mask[BIT_TMR2_MASK]));
    // Enables are zero only under reset, which is the Off mode
    next_s.clko_oe = 1'b1;
    next_s.irq_oe = 1'b1;
    next_s.rx_on = next_s.mode == MODE_RX;
    next_s.tx_on = next_s.mode == MODE_TX;
    next_s.cca_on = next_s.mode == MODE_CCA;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.mode <= MODE_OFF;
      s.irq_mask <= REG_RESET;
      s.seq_ctrl <= REG_RESET;
      s.lp_ctrl <= REG_RESET;
      s.clko_ctrl <= REG_RESET;
      s.status <= REG_RESET;
      s.irq_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign clko       = s.clko;
  assign clko_oe    = s.clko_oe;
  assign irq_n      = s.irq_n;
  assign irq_n_oe   = s.irq_oe;
  assign osc_enable = s.osc;
  assign rx_on      = s.rx_on;
  assign tx_on      = s.tx_on;
  assign cca_on     = s.cca_on;
endmodule

// ===== src/power_mode_pkg.sv
// Purpose: shared constants and mode type of the transceiver power-mode controller
// Assumes: 250 MHz reference clock, 6-bit register addresses, 16-bit register data
// Notes:   long cycle counts are defaults for parameters of the top module
package power_mode_pkg;

  // Register addresses
  localparam logic [5:0] ADDR_IRQ_MASK   = 6'h05;
  localparam logic [5:0] ADDR_SEQ_CTRL   = 6'h06;
  localparam logic [5:0] ADDR_LP_CTRL    = 6'h07;
  localparam logic [5:0] ADDR_CLKO_CTRL  = 6'h09;
  localparam logic [5:0] ADDR_WAKE_HI    = 6'h1D;
  localparam logic [5:0] ADDR_WAKE_LO    = 6'h1E;
  localparam logic [5:0] ADDR_STREAM_CMP = 6'h1F;
  localparam logic [5:0] ADDR_IRQ_STATUS = 6'h24;
  localparam logic [5:0] ADDR_MODE_STAT  = 6'h25;

  // Field positions
  localparam int BIT_DOZE_EN     = 0;
  localparam int BIT_HIB_EN      = 1;
  localparam int BIT_CLKO_DOZE   = 9;
  localparam int BIT_TMR2_MASK   = 1;
  localparam int BIT_DOZE_MASK   = 4;
  localparam int BIT_ACOMA_EN    = 8;
  localparam int BIT_CLKO_EN     = 2;
  localparam int CLKO_RATE_LSB   = 5;
  localparam int BIT_TX_STRM     = 4;
  localparam int BIT_RX_STRM     = 5;
  localparam int BIT_USE_STRM    = 6;
  localparam int BIT_TRIG_EN     = 7;
  localparam int BIT_ST_TMR2     = 2;
  localparam int BIT_ST_DOZE     = 9;

  // Sequence codes, reset values and limits
  localparam logic [1:0]  SEQ_IDLE      = 2'h0;
  localparam logic [1:0]  SEQ_CCA       = 2'h1;
  localparam logic [1:0]  SEQ_RX        = 2'h2;
  localparam logic [1:0]  SEQ_TX        = 2'h3;
  localparam logic [15:0] REG_RESET     = 16'h0000;
  localparam logic [2:0]  CLKO_SLOW_MIN = 3'h6;
  localparam logic [7:0]  LP_EDGES_LAST = 8'h7F;
  localparam logic [4:0]  PIN_RESET     = 5'h12;

  // Timing
  localparam int CLK_MHZ           = 250;
  localparam int T_OFF_TO_IDLE_MS  = 25;
  localparam int T_HIB_TO_IDLE_MS  = 20;
  localparam int T_DOZE_EXIT_US    = 300;
  localparam int T_WARMUP_US       = 144;
  localparam int PRESCALE_DIV      = 250;
  localparam logic [22:0] CYC_OFF_TO_IDLE = 23'(T_OFF_TO_IDLE_MS * CLK_MHZ * 1000);
  localparam logic [22:0] CYC_HIB_TO_IDLE = 23'(T_HIB_TO_IDLE_MS * CLK_MHZ * 1000);
  localparam logic [22:0] CYC_DOZE_EXIT   = 23'(T_DOZE_EXIT_US * CLK_MHZ);
  localparam logic [22:0] CYC_WARMUP      = 23'(T_WARMUP_US * CLK_MHZ);

  typedef enum logic [3:0] {
    MODE_OFF, MODE_BOOT, MODE_IDLE, MODE_ENTER, MODE_HIBERNATE, MODE_HIB_WAKE,
    MODE_DOZE, MODE_DOZE_WAKE, MODE_ARMED, MODE_WARMUP, MODE_RX, MODE_TX, MODE_CCA
  } mode_t;

endpackage

// ===== src/pin_sync.sv
// Purpose: two-stage synchroniser for a group of asynchronous pins
// Assumes: each bit is an independent level
// Notes:   only the second stage is visible outside
`timescale 1ns/10ps
module pin_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pins,
  output logic      [WIDTH-1:0] synced
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_t;

  sync_t s;
  sync_t next_s;

  if (WIDTH < 1) begin : g_chk
    $error("pin_sync needs at least one bit");
  end

  always_comb begin
    next_s.stage1 = pins;
    next_s.stage2 = s.stage1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= {RESET_VAL, RESET_VAL};
    end else begin
      s <= next_s;
    end
  end

  assign synced = s.stage2;
endmodule

// ===== src/serial_reg_port.sv
// Purpose: serial register port, 8-bit header then 16 data bits, MSB first
// Assumes: clock and select already synchronised; serial clock far below clk
// Notes:   header bit 7 set means read, bits 5:0 are the address
`timescale 1ns/10ps
module serial_reg_port (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        enable,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        mosi,
  input  wire logic [15:0] rdata,
  output logic             rd_req,
  output logic             wr_req,
  output logic      [5:0]  addr,
  output logic      [15:0] wdata,
  output logic             miso,
  output logic             miso_oe
);
  typedef struct packed {
    logic        prev_sclk;
    logic [4:0]  bit_cnt;
    logic [15:0] shift;
    logic [15:0] tx;
    logic        is_read;
    logic [5:0]  addr;
    logic [15:0] wdata;
    logic        rd_req;
    logic        wr_req;
    logic        miso;
    logic        miso_oe;
  } port_t;

  port_t s;
  port_t next_s;

  always_comb begin
    next_s = s;
    next_s.rd_req = 1'b0;
    next_s.wr_req = 1'b0;
    next_s.prev_sclk = sclk;
    if (!enable || cs_n) begin
      // Port dead outside Idle and active modes
      next_s.bit_cnt = 5'h00;
      next_s.miso = 1'b0;
      next_s.miso_oe = 1'b0;
    end else begin
      next_s.miso_oe = 1'b1;
      if (s.rd_req) begin
        next_s.tx = rdata;
      end
      if (sclk && !s.prev_sclk && s.bit_cnt != 5'h1F) begin
        next_s.shift = {s.shift[14:0], mosi};
        next_s.bit_cnt = s.bit_cnt + 5'h01;
        if (s.bit_cnt == 5'h07) begin
          next_s.is_read = s.shift[6];
          next_s.addr = {s.shift[4:0], mosi};
          next_s.rd_req = s.shift[6];
        end
        if (s.bit_cnt == 5'h17 && !s.is_read) begin
          next_s.wdata = {s.shift[14:0], mosi};
          next_s.wr_req = 1'b1;
        end
      end
      if (!sclk && s.prev_sclk && s.bit_cnt >= 5'h08) begin
        next_s.miso = s.tx[15];
        next_s.tx = {s.tx[14:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rd_req  = s.rd_req;
  assign wr_req  = s.wr_req;
  assign addr    = s.addr;
  assign wdata   = s.wdata;
  assign miso    = s.miso;
  assign miso_oe = s.miso_oe;
endmodule

// ===== dv/host_mcu_model.sv
// Purpose: host side of the serial register port
// Assumes: frames of 8 header bits then 16 data bits, MSB first
// Notes:   sclk halves of 6 clk cycles leave margin over the two-flop sync
`timescale 1ns/10ps
module host_mcu_model (
  input  wire logic clk,
  input  wire logic miso,
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // Caller talks only while the device is awake
  task automatic frame(input logic [7:0] hdr, input logic [15:0] wd, output logic [15:0] rd);
    logic [23:0] sh;
    sh = {hdr, wd};
    rd = 16'h0000;
    @(negedge clk);
    cs_n = 1'b0;
    for (int i = 0; i < 24; i++) begin
      mosi = sh[23-i];
      repeat (6) @(negedge clk);
      sclk = 1'b1;
      if (i > 7) rd = {rd[14:0], miso};
      repeat (6) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (6) @(negedge clk);
    cs_n = 1'b1;
    // Released line must not look like a held value
    mosi = ~mosi;
    repeat (6) @(negedge clk);
  endtask
endmodule

// ===== dv/transceiver_power_mode_ctrl_properties.sv
// Purpose: port-level checks of the power-mode controller
// Assumes: one clock domain, rst asynchronous active high
// Notes:   mode is not visible at the ports, so oscillator enable stands for Hibernate
`timescale 1ns/10ps
module transceiver_power_mode_ctrl_properties #(
  parameter logic [22:0] OFF_TO_IDLE_CYCLES = 23'h000032
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic radio_activity_enable_pin,
  input wire logic spi_cs_n,
  input wire logic op_done,
  input wire logic spi_miso_oe,
  input wire logic clko,
  input wire logic clko_oe,
  input wire logic irq_n_oe,
  input wire logic osc_enable,
  input wire logic rx_on,
  input wire logic tx_on,
  input wire logic cca_on
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  logic [22:0] since_rel;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) since_rel <= '0;
    else if (since_rel != '1) since_rel <= since_rel + 23'h000001;
  end

  sequence s_op_end;
    (rx_on || tx_on || cca_on) && op_done;
  endsequence

  a_off_outputs_released: assert property (disable iff (1'b0)
    rst |-> !clko_oe && !irq_n_oe && !spi_miso_oe) else $error("output driven in Off");
  a_oe_after_release: assert property ($fell(rst) |=> (clko_oe && irq_n_oe) [*4])
    else $error("outputs not driven after reset");
  a_boot_port_quiet: assert property (
    since_rel < OFF_TO_IDLE_CYCLES |-> !spi_miso_oe) else $error("port live during boot");
  a_unselected_port_off: assert property (spi_cs_n [*8] |-> !spi_miso_oe)
    else $error("data out driven while unselected");
  a_hib_clko_still: assert property (
    !osc_enable && !$past(osc_enable) |-> !clko && !spi_miso_oe) else $error("active in Hibernate");
  a_hib_radio_off: assert property (!osc_enable |-> !(rx_on || tx_on || cca_on))
    else $error("radio on with oscillator stopped");
  a_one_radio_mode: assert property ($onehot0({rx_on, tx_on, cca_on}))
    else $error("two radio modes at once");
  a_op_returns_idle: assert property (s_op_end |-> ##[1:3] !(rx_on || tx_on || cca_on))
    else $error("no return to Idle after done");
  a_pin_gates_radio: assert property (
    $rose(rx_on || tx_on || cca_on) |-> $past(radio_activity_enable_pin, 3))
    else $error("radio started with enable pin low");
endmodule

bind transceiver_power_mode_ctrl transceiver_power_mode_ctrl_properties #(
  .OFF_TO_IDLE_CYCLES(OFF_TO_IDLE_CYCLES)
) props_inst (.clk(clk), .rst(rst), .radio_activity_enable_pin(radio_activity_enable_pin),
  .spi_cs_n(spi_cs_n), .op_done(op_done), .spi_miso_oe(spi_miso_oe), .clko(clko),
  .clko_oe(clko_oe), .irq_n_oe(irq_n_oe), .osc_enable(osc_enable), .rx_on(rx_on),
  .tx_on(tx_on), .cca_on(cca_on));

// ===== dv/transceiver_power_mode_ctrl_tb.sv
// Purpose: self-checking bench of the power-mode controller
// Assumes: shortened counts, event timer ticks every 4 clk once boot has ended and Idle is reached
// Notes:   wake compare is set from a cycle count, so margins are generous
`timescale 1ns/10ps
module transceiver_power_mode_ctrl_tb;
  import power_mode_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b0;
  logic wake_pin_n = 1'b1;
  logic radio_activity_enable_pin = 1'b0;
  logic op_done = 1'b0;
  wire  sclk, cs_n, mosi, miso, miso_oe, clko, clko_oe, irq_n, irq_n_oe, osc_enable;
  wire  rx_on, tx_on, cca_on;
  int   mismatches = 0, tests_run = 0, cyc = 0, n;
  logic [15:0] v, d;
  logic [5:0] regs [8] = '{ADDR_IRQ_MASK, ADDR_SEQ_CTRL, ADDR_LP_CTRL, ADDR_CLKO_CTRL,
                           ADDR_WAKE_HI, ADDR_WAKE_LO, ADDR_IRQ_STATUS, 6'h3A};
  logic [7:0] codes [5] = '{8'h01, 8'h02, 8'h03, 8'h50, 8'h60};

  always #2 clk = ~clk;
  always @(posedge clk) cyc <= rst ? 0 : cyc + 1;

  transceiver_power_mode_ctrl #(.OFF_TO_IDLE_CYCLES(23'h000032), .HIB_TO_IDLE_CYCLES(23'h000028),
    .DOZE_EXIT_CYCLES(23'h00001E), .WARMUP_CYCLES(23'h000014), .PRESCALE(4)
  ) transceiver_power_mode_ctrl_inst (.clk(clk), .rst(rst), .wake_pin_n(wake_pin_n),
    .radio_activity_enable_pin(radio_activity_enable_pin), .spi_sclk(sclk), .spi_cs_n(cs_n),
    .spi_mosi(mosi), .op_done(op_done), .spi_miso(miso), .spi_miso_oe(miso_oe), .clko(clko),
    .clko_oe(clko_oe), .irq_n(irq_n), .irq_n_oe(irq_n_oe), .osc_enable(osc_enable),
    .rx_on(rx_on), .tx_on(tx_on), .cca_on(cca_on));

  host_mcu_model host_mcu_model_inst (.clk(clk), .miso(miso), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] wd);
    logic [15:0] r;
    host_mcu_model_inst.frame({2'b00, a}, wd, r);
  endtask

  task automatic rd(input logic [5:0] a, output logic [15:0] r);
    host_mcu_model_inst.frame({2'b10, a}, 16'h0000, r);
  endtask

  // Timer value is cycles over the prescale, so this is only good before Acoma Doze or Hibernate
  task automatic set_wake(input int ahead);
    logic [23:0] t;
    t = 24'(cyc / 4 + ahead);
    wr(ADDR_WAKE_HI, {8'h00, t[23:16]});
    wr(ADDR_WAKE_LO, t[15:0]);
  endtask

  task automatic clko_check(input logic exp);
    logic moved;
    logic last;
    moved = 1'b0;
    last = clko;
    repeat (8) begin
      @(negedge clk);
      moved |= (clko !== last);
      last = clko;
    end
    check(16'(moved), 16'(exp));
  endtask

  // Expected {cca_on, rx_on, tx_on} for a sequence register value
  function automatic logic [2:0] radio_exp(input logic [7:0] c);
    if (c[6]) return c[4] ? 3'h1 : 3'h2;
    return (c[1:0] == 2'h1) ? 3'h4 : (c[1:0] == 2'h2) ? 3'h2 : 3'h1;
  endfunction

  task automatic tally_and_finish;
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #360000;
    mismatches++;
    tally_and_finish;
  end

  initial begin
    void'($urandom(25163));
    // Edge on rst before the first clock, so no state is unknown at it
    #1 rst = 1'b1;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (70) @(negedge clk);
    rd(ADDR_MODE_STAT, v); check(v, {12'h000, MODE_IDLE});
    foreach (regs[i]) begin
      rd(regs[i], v); check(v, REG_RESET);
    end
    d = 16'($urandom);
    wr(ADDR_WAKE_LO, d);
    rd(ADDR_WAKE_LO, v); check(v, d);
    wr(ADDR_CLKO_CTRL, 16'h0004);
    foreach (codes[i]) begin
      wr(ADDR_SEQ_CTRL, {8'h00, codes[i]});
      repeat (40) @(negedge clk);
      check(16'({cca_on, rx_on, tx_on}), 16'h0000);
      radio_activity_enable_pin = 1'b1;
      n = 0;
      while ({cca_on, rx_on, tx_on} === 3'h0 && n < 100) begin @(negedge clk); n++; end
      check(16'(n >= 20 && n <= 30), 16'h0001);
      check(16'({cca_on, rx_on, tx_on}), 16'(radio_exp(codes[i])));
      repeat ($urandom_range(1, 8)) @(negedge clk);
      op_done = 1'b1;
      @(negedge clk);
      op_done = 1'b0;
      radio_activity_enable_pin = 1'b0;
      repeat (4) @(negedge clk);
      check(16'({cca_on, rx_on, tx_on}), 16'h0000);
    end
    set_wake(400);
    wr(ADDR_SEQ_CTRL, 16'h0082);
    radio_activity_enable_pin = 1'b1;
    repeat (200) @(negedge clk);
    check(16'(rx_on), 16'h0000);
    n = 0;
    while (rx_on !== 1'b1 && n < 2000) begin @(negedge clk); n++; end
    check(16'(rx_on), 16'h0001);
    op_done = 1'b1;
    @(negedge clk);
    op_done = 1'b0;
    radio_activity_enable_pin = 1'b0;
    rd(ADDR_IRQ_STATUS, v); check(v, 16'h0004);
    wr(ADDR_STREAM_CMP, 16'(cyc / 4 + 300));
    wr(ADDR_SEQ_CTRL, 16'h00D0);
    radio_activity_enable_pin = 1'b1;
    repeat (200) @(negedge clk);
    check(16'(tx_on), 16'h0000);
    n = 0;
    while (tx_on !== 1'b1 && n < 2000) begin @(negedge clk); n++; end
    check(16'(tx_on), 16'h0001);
    op_done = 1'b1;
    @(negedge clk);
    op_done = 1'b0;
    radio_activity_enable_pin = 1'b0;
    rd(ADDR_IRQ_STATUS, v); check(v, 16'h0004);
    wr(ADDR_IRQ_MASK, 16'h0010);
    set_wake(500);
    wr(ADDR_LP_CTRL, 16'h0001);
    repeat (800) @(negedge clk);
    clko_check(1'b0);
    check(16'(osc_enable), 16'h0001);
    n = 0;
    while (irq_n !== 1'b0 && n < 2000) begin @(negedge clk); n++; end
    check(16'(irq_n), 16'h0000);
    // Port stays dead until the exit delay is over
    repeat (40) @(negedge clk);
    rd(ADDR_IRQ_STATUS, v); check(v, 16'h0200);
    check(16'(irq_n), 16'h0001);
    clko_check(1'b1);
    wr(ADDR_IRQ_MASK, 16'h0110);
    set_wake(450);
    wr(ADDR_LP_CTRL, 16'h0001);
    repeat (1600) @(negedge clk);
    check(16'(irq_n), 16'h0001);
    clko_check(1'b1);
    wake_pin_n = 1'b0;
    repeat (200) @(negedge clk);
    wake_pin_n = 1'b1;
    rd(ADDR_IRQ_STATUS, v); check(v, 16'h0000);
    // No disable bit here, so the armed compare is pushed out of reach
    wr(ADDR_WAKE_HI, 16'h00FF);
    wr(ADDR_LP_CTRL, 16'h0002);
    n = 0;
    while (osc_enable !== 1'b0 && n < 400) begin @(negedge clk); n++; end
    check(16'(n >= 240 && n <= 270), 16'h0001);
    repeat (50) @(negedge clk);
    wake_pin_n = 1'b0;
    repeat (60) @(negedge clk);
    wake_pin_n = 1'b1;
    rd(ADDR_MODE_STAT, v); check(v, {12'h000, MODE_IDLE});
    rd(ADDR_IRQ_MASK, v); check(v, 16'h0110);
    clko_check(1'b1);
    wr(ADDR_IRQ_MASK, 16'h0010);
    wr(ADDR_CLKO_CTRL, 16'h00C4);
    wr(ADDR_LP_CTRL, 16'h0001);
    // Slow rate: 128 output cycles to enter, 128 more until the output stops
    repeat (33000) @(negedge clk);
    wake_pin_n = 1'b0;
    repeat (300) @(negedge clk);
    wake_pin_n = 1'b1;
    wr(ADDR_CLKO_CTRL, 16'h0004);
    clko_check(1'b0);
    wr(ADDR_CLKO_CTRL, 16'h0000);
    wr(ADDR_CLKO_CTRL, 16'h0004);
    clko_check(1'b1);
    wr(ADDR_LP_CTRL, 16'h0002);
    repeat (400) @(negedge clk);
    rst = 1'b1;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (70) @(negedge clk);
    rd(ADDR_IRQ_MASK, v); check(v, REG_RESET);
    tally_and_finish;
  end
endmodule
